// ---- bectl_pkg.sv ----
package bectl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets from the control-register base, bus width
   localparam int unsigned BECTL_ADDR_W     = 6;
   localparam logic [5:0]  BECTL_ADDR_ROUTE = 6'h24;
   localparam logic [5:0]  BECTL_ADDR_MISC  = 6'h28;
   localparam logic [0:7]  BECTL_UNMAPPED   = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // reset values, bit 0 is the most significant data line
   localparam logic [0:6]  BECTL_ROUTE_RST  = 7'h00;
   localparam logic [0:7]  BECTL_MISC_RST   = 8'h80;

   ////////////////////////////////////////////////////////////////////////
   // ethernet route config fields
   localparam int BECTL_MODE_LO      = 0;
   localparam int BECTL_MODE_HI      = 3;
   localparam int BECTL_HOST_PHY     = 4;
   localparam int BECTL_SLAVE_PHY    = 5;
   localparam int BECTL_WIDEBAND     = 6;

   // misc port/codec config fields
   localparam int BECTL_ADDR_MSB     = 0;
   localparam int BECTL_TRACE_EN     = 1;
   localparam int BECTL_CODEC_PATH   = 2;

   // positions in the pin synchroniser
   localparam int BECTL_SYNC_TYPE_HI = 0;
   localparam int BECTL_SYNC_TYPE_LO = 1;
   localparam int BECTL_SYNC_DIP_N   = 2;
   localparam int BECTL_SYNC_FSYNC   = 3;
   localparam int BECTL_SYNC_W       = 4;

   ////////////////////////////////////////////////////////////////////////
   // route modes in field order, so each takes its encoded value
   typedef enum logic [3:0] {
      MODE_LEGACY_OFF, MODE_SW_RMII_HOST, MODE_SW_RMII_TDM,
      MODE_SW_SMII_TDM, MODE_LB_RMII_TDM, MODE_LB_RMII_HOST,
      MODE_LB_SMII_TDM, MODE_SMIIPHY_TDM, MODE_RMIIPHY_TDM,
      MODE_RMIIPHY_HOST, MODE_MIIPHY_TDM, MODE_MIIPHY_HOST,
      MODE_CPU_TDM, MODE_CPU_HOST, MODE_SPARE_A, MODE_SPARE_B
   } bectl_mode_t;

   typedef enum logic [2:0] {
      DEST_NONE, DEST_SWITCH, DEST_SMII_PHY, DEST_RMII_PHY,
      DEST_MII_PHY, DEST_HOST_CPU
   } bectl_dest_t;

   typedef enum logic [1:0] {
      IF_NONE, IF_RMII, IF_SMII, IF_MII
   } bectl_iface_t;

endpackage

// ---- bectl_route_decode.sv ----
`timescale 1ns/100ps
module bectl_route_decode
   import bectl_pkg::*;
(
   input  wire bectl_mode_t  mode,
   input  wire logic         enable,
   output bectl_dest_t       dest,
   output bectl_iface_t      iface,
   output logic              from_host_port,
   output logic              loopback
);

   always_comb begin
      dest           = DEST_NONE;
      iface          = IF_NONE;
      from_host_port = 1'b0;
      loopback       = 1'b0;
      // muxes stay parked until both ethernet-on sources agree
      if (enable) begin
         case (mode)
            MODE_SW_RMII_HOST, MODE_LB_RMII_HOST: begin
               dest           = DEST_SWITCH;
               iface          = IF_RMII;
               from_host_port = 1'b1;
            end
            MODE_SW_RMII_TDM, MODE_LB_RMII_TDM: begin
               dest  = DEST_SWITCH;
               iface = IF_RMII;
            end
            MODE_SW_SMII_TDM, MODE_LB_SMII_TDM: begin
               dest  = DEST_SWITCH;
               iface = IF_SMII;
            end
            MODE_SMIIPHY_TDM: begin
               dest  = DEST_SMII_PHY;
               iface = IF_SMII;
            end
            MODE_RMIIPHY_TDM, MODE_RMIIPHY_HOST: begin
               dest           = DEST_RMII_PHY;
               iface          = IF_RMII;
               from_host_port = (mode == MODE_RMIIPHY_HOST);
            end
            MODE_MIIPHY_TDM, MODE_MIIPHY_HOST: begin
               dest           = DEST_MII_PHY;
               iface          = IF_MII;
               from_host_port = (mode == MODE_MIIPHY_HOST);
            end
            MODE_CPU_TDM, MODE_CPU_HOST: begin
               dest           = DEST_HOST_CPU;
               iface          = IF_MII;
               from_host_port = (mode == MODE_CPU_HOST);
            end
            default: begin
               dest = DEST_NONE;
            end
         endcase
         loopback = (mode == MODE_LB_RMII_TDM) ||
                    (mode == MODE_LB_RMII_HOST) ||
                    (mode == MODE_LB_SMII_TDM);
      end
   end

endmodule

// ---- bectl_regs.sv ----
`timescale 1ns/100ps
// How it works
// - ethernet route config is one byte at offset 0x24, upper bits absent
// - bits 0-3 pick the route, reset 0000 means all ethernet off
// - 0001/0010 rmii host/tdm port to switch, 0011 smii tdm to switch
// - 0100, 0101, 0110 repeat 0010, 0001, 0011 plus mezzanine loopback
// - 0111 smii tdm to smii phy, 1000/1001 rmii tdm/host to rmii phy
// - 1010/1011 connect tdm or host port over mii to mii phy
// - 1100/1101 mii straight to host processor, 1110/1111 route nothing
// - bit 4 enables host mii phy, reset 0; keep low during i2c use
// - bit 5 enables the slave rmii/mii phy, reset 0
// - bit 6 selects 16 kHz codec; interchanger still gets 8 kHz sync
// - bit 7 read-only slave type low bit, reset 0; code 11 unused
// - misc port/codec config sits at offset 0x28
// - misc bit 0, reset 1, is top bit of slave address mode code
// - misc bit 1 enables the trace connector data buffers
// - misc bit 2 low routes codec to tdm, high via interchanger
// - companion read-only pin gives the slave type high bit
module bectl_regs
   import bectl_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    srst,
   input  wire logic [BECTL_ADDR_W-1:0] bus_addr,
   input  wire logic                    bus_cs_n,
   input  wire logic                    bus_write,
   input  wire logic [0:7]              bus_data_in,
   output logic [0:7]                   bus_data_out,
   output logic                         bus_data_oe_n,
   input  wire logic                    eth_enable_bit,
   input  wire logic                    eth_dip_on_n,
   input  wire logic                    slave_type_high_bit,
   input  wire logic                    slave_type_low_bit,
   input  wire logic [0:1]              aux_addr_mode_low,
   input  wire logic                    codec_fsync,
   output bectl_dest_t                  route_dest,
   output bectl_iface_t                 route_iface,
   output logic                         route_from_host_port,
   output logic                         mezz_loopback,
   output logic                         host_phy_enable,
   output logic                         slave_phy_enable,
   output logic                         codec_wideband_enable,
   output logic [1:0]                   slave_type_code,
   output logic [0:2]                   slave_port_addr_mode,
   output logic                         trace_buffer_enable,
   output logic                         codec_path_select,
   output logic                         tsi_frame_sync
);

   logic [0:6]              route_cfg;
   logic [0:7]              misc_cfg;
   logic [BECTL_SYNC_W-1:0] pin_meta;
   logic [BECTL_SYNC_W-1:0] pin_sync;
   logic                    fsync_prev;
   logic                    pass_phase;
   logic                    wr_route;
   logic                    wr_misc;
   logic                    rd_hit;
   logic [0:7]              rd_word;
   logic                    route_on;
   bectl_mode_t             mode;
   bectl_dest_t             next_dest;
   bectl_iface_t            next_iface;
   logic                    next_from_host;
   logic                    next_loopback;

   ////////////////////////////////////////////////////////////////////////
   // pins from switches, straps and the codec

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {codec_fsync, eth_dip_on_n,
                      slave_type_low_bit, slave_type_high_bit};
         pin_sync <= pin_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register access, byte wide, host bus clock

   always_comb begin
      wr_route = !bus_cs_n && bus_write && (bus_addr == BECTL_ADDR_ROUTE);
      wr_misc  = !bus_cs_n && bus_write && (bus_addr == BECTL_ADDR_MISC);
      rd_hit   = 1'b0;
      rd_word  = BECTL_UNMAPPED;
      // full byte read back, bit 7 from the pin
      if (bus_addr == BECTL_ADDR_ROUTE) begin
         rd_hit  = 1'b1;
         rd_word = {route_cfg, pin_sync[BECTL_SYNC_TYPE_LO]};
      end else if (bus_addr == BECTL_ADDR_MISC) begin
         rd_hit  = 1'b1;
         rd_word = misc_cfg;
      end
   end

   // route field and enables reset low
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         route_cfg <= BECTL_ROUTE_RST;
      end else if (wr_route) begin
         // read-only bit 7 is not stored
         route_cfg <= bus_data_in[0:6];
      end
   end

   // misc byte, address msb resets high
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         misc_cfg <= BECTL_MISC_RST;
      end else if (wr_misc) begin
         misc_cfg <= bus_data_in;
      end
   end

   // data lines are driven only in the cycle after a mapped read is sampled
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_data_out  <= BECTL_UNMAPPED;
         bus_data_oe_n <= 1'b1;
      end else begin
         bus_data_out  <= rd_word;
         bus_data_oe_n <= !(!bus_cs_n && !bus_write && rd_hit);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ethernet routing

   // both ethernet-on sources gate the muxes
   assign route_on = eth_enable_bit && !pin_sync[BECTL_SYNC_DIP_N];
   assign mode     = bectl_mode_t'(route_cfg[BECTL_MODE_LO:BECTL_MODE_HI]);

   bectl_route_decode u_decode (
      .mode           (mode),
      .enable         (route_on),
      .dest           (next_dest),
      .iface          (next_iface),
      .from_host_port (next_from_host),
      .loopback       (next_loopback)
   );

   // registered so no decode glitch reaches the mux selects
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         route_dest           <= DEST_NONE;
         route_iface          <= IF_NONE;
         route_from_host_port <= 1'b0;
         mezz_loopback        <= 1'b0;
      end else begin
         route_dest           <= next_dest;
         route_iface          <= next_iface;
         route_from_host_port <= next_from_host;
         mezz_loopback        <= next_loopback;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enables and static selects

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         host_phy_enable       <= 1'b0;
         slave_phy_enable      <= 1'b0;
         codec_wideband_enable <= 1'b0;
         slave_type_code       <= 2'h0;
         slave_port_addr_mode  <= 3'h0;
         trace_buffer_enable   <= 1'b0;
         codec_path_select     <= 1'b0;
      end else begin
         host_phy_enable       <= route_cfg[BECTL_HOST_PHY];
         slave_phy_enable      <= route_cfg[BECTL_SLAVE_PHY];
         codec_wideband_enable <= route_cfg[BECTL_WIDEBAND];
         slave_type_code       <= {pin_sync[BECTL_SYNC_TYPE_HI],
                                   pin_sync[BECTL_SYNC_TYPE_LO]};
         // msb here, low bits from aux register
         slave_port_addr_mode  <= {misc_cfg[BECTL_ADDR_MSB],
                                   aux_addr_mode_low};
         trace_buffer_enable   <= misc_cfg[BECTL_TRACE_EN];
         codec_path_select     <= misc_cfg[BECTL_CODEC_PATH];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame sync toward the interchanger

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fsync_prev <= 1'b0;
         pass_phase <= 1'b1;
      end else begin
         fsync_prev <= pin_sync[BECTL_SYNC_FSYNC];
         // flip on each falling edge, every other pulse passes
         if (fsync_prev && !pin_sync[BECTL_SYNC_FSYNC]) begin
            pass_phase <= !pass_phase;
         end
      end
   end

   // narrowband passes every pulse; phase is left free so a mode
   // change may shorten at most one pulse
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tsi_frame_sync <= 1'b0;
      end else if (route_cfg[BECTL_WIDEBAND]) begin
         tsi_frame_sync <= pin_sync[BECTL_SYNC_FSYNC] && pass_phase;
      end else begin
         tsi_frame_sync <= pin_sync[BECTL_SYNC_FSYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   property p_route_write;
      wr_route |=> route_cfg == $past(bus_data_in[0:6]);
   endproperty
   a_route_write: assert property (p_route_write)
      else $error("route config write not stored");

   property p_reset_values;
      $fell(srst) |-> route_cfg == BECTL_ROUTE_RST &&
                      misc_cfg == BECTL_MISC_RST;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("config registers not at reset value");

   property p_switch_rmii;
      route_on && mode == MODE_SW_RMII_HOST |=>
         route_dest == DEST_SWITCH && route_iface == IF_RMII &&
         route_from_host_port && !mezz_loopback;
   endproperty
   a_switch_rmii: assert property (p_switch_rmii)
      else $error("host port rmii to switch not routed");

   property p_loopback;
      route_on && mode inside {MODE_LB_RMII_TDM, MODE_LB_RMII_HOST,
                               MODE_LB_SMII_TDM} |=>
         mezz_loopback && route_dest == DEST_SWITCH;
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("loopback mode without loopback to switch");

   property p_phy_routes;
      route_on && mode == MODE_RMIIPHY_HOST |=>
         route_dest == DEST_RMII_PHY && route_iface == IF_RMII &&
         route_from_host_port;
   endproperty
   a_phy_routes: assert property (p_phy_routes)
      else $error("rmii phy route wrong");

   property p_mii_phy;
      route_on && mode == MODE_MIIPHY_TDM |=>
         route_dest == DEST_MII_PHY && route_iface == IF_MII &&
         !route_from_host_port;
   endproperty
   a_mii_phy: assert property (p_mii_phy)
      else $error("mii phy route wrong");

   property p_spare_or_off;
      (!route_on || mode inside {MODE_SPARE_A, MODE_SPARE_B,
                                 MODE_LEGACY_OFF}) |=>
         route_dest == DEST_NONE && route_iface == IF_NONE;
   endproperty
   a_spare_or_off: assert property (p_spare_or_off)
      else $error("route active while off or spare");

   property p_phy_enables;
      ##1 host_phy_enable == $past(route_cfg[BECTL_HOST_PHY]) &&
          slave_phy_enable == $past(route_cfg[BECTL_SLAVE_PHY]);
   endproperty
   a_phy_enables: assert property (p_phy_enables)
      else $error("phy enable does not follow register");

   property p_wideband_gate;
      route_cfg[BECTL_WIDEBAND] && !pass_phase |=> !tsi_frame_sync;
   endproperty
   a_wideband_gate: assert property (p_wideband_gate)
      else $error("skipped frame sync reached interchanger");

   property p_type_readback;
      !bus_cs_n && !bus_write && bus_addr == BECTL_ADDR_ROUTE |=>
         !bus_data_oe_n &&
         bus_data_out[7] == $past(pin_sync[BECTL_SYNC_TYPE_LO]);
   endproperty
   a_type_readback: assert property (p_type_readback)
      else $error("slave type bit not read back");

   property p_misc_outputs;
      wr_misc |=> ##1 trace_buffer_enable == $past(bus_data_in[1], 2) &&
                      codec_path_select == $past(bus_data_in[2], 2) &&
                      slave_port_addr_mode[0] == $past(bus_data_in[0], 2);
   endproperty
   a_misc_outputs: assert property (p_misc_outputs)
      else $error("misc outputs do not follow write");

   property p_unmapped;
      bus_addr != BECTL_ADDR_ROUTE && bus_addr != BECTL_ADDR_MISC |=>
         bus_data_oe_n;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("data driven for unmapped offset");

   c_cpu_route: cover property (route_on && mode == MODE_CPU_HOST ##1
                                route_dest == DEST_HOST_CPU);
   c_wideband: cover property (route_cfg[BECTL_WIDEBAND] ##1
                               tsi_frame_sync);
   c_misc_read: cover property (!bus_cs_n && !bus_write &&
                                bus_addr == BECTL_ADDR_MISC);

endmodule

// ---- bectl_host_model.sv ----
`timescale 1ns/100ps
module bectl_host_model
   import bectl_pkg::*;
(
   input  wire logic                    sys_clk,
   output logic [BECTL_ADDR_W-1:0]      bus_addr,
   output logic                         bus_cs_n,
   output logic                         bus_write,
   output logic [0:7]                   bus_data_in,
   input  wire logic [0:7]              bus_data_out,
   input  wire logic                    bus_data_oe_n,
   output logic                         eth_enable_bit,
   output logic                         eth_dip_on_n
);
   logic       smii_phy_reset_n;
   logic [0:7] last_seen;

   initial begin
      bus_addr = '0;
      bus_cs_n = 1'b1;
      bus_write = 1'b0;
      bus_data_in = 8'h00;
      eth_enable_bit = 1'b0;
      eth_dip_on_n = 1'b1;
      smii_phy_reset_n = 1'b1;
      last_seen = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // one byte write, taken at the rising edge between the two falls
   task automatic wr(input logic [BECTL_ADDR_W-1:0] a, input logic [0:7] d);
      @(negedge sys_clk);
      if (a == BECTL_ADDR_ROUTE && (d[0:3] == 4'hC || d[0:3] == 4'hD)) begin
         smii_phy_reset_n = 1'b0;
      end
      bus_addr = a;
      bus_write = 1'b1;
      bus_data_in = d;
      bus_cs_n = 1'b0;
      @(negedge sys_clk);
      bus_cs_n = 1'b1;
      bus_write = 1'b0;
      // released lines must not look like the last byte
      bus_data_in = ~d;
   endtask

   task automatic rd(input logic [BECTL_ADDR_W-1:0] a, output logic [0:7] d,
                     output logic oe_n);
      @(negedge sys_clk);
      bus_addr = a;
      bus_write = 1'b0;
      bus_cs_n = 1'b0;
      @(negedge sys_clk);
      oe_n = bus_data_oe_n;
      // undriven data lines read back as garbage
      d = bus_data_oe_n ? ~last_seen : bus_data_out;
      last_seen = d;
      bus_cs_n = 1'b1;
   endtask

   task automatic eth_on(input logic en, input logic dip_n);
      @(negedge sys_clk);
      eth_enable_bit = en;
      eth_dip_on_n = dip_n;
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top
   import bectl_pkg::*;
;
   logic                    sys_clk, srst, bus_cs_n, bus_write, oe_n;
   logic [BECTL_ADDR_W-1:0] bus_addr;
   logic [0:7]              bus_data_in, bus_data_out;
   logic                    eth_en, dip_n, type_hi, type_lo, fsync, tsi_fs;
   logic [0:1]              aux_lo;
   bectl_dest_t             route_dest;
   bectl_iface_t            route_iface;
   logic                    host_port, loopback, host_phy, slave_phy, wide;
   logic [1:0]              type_code;
   logic [0:2]              addr_mode;
   logic                    trace_en, codec_path;
   int                      error_cnt, num_checks, cycles, fs_count;
   logic                    fs_prev;
   // {loopback, host port, iface, dest} per route mode
   localparam logic [7:0]   route_tab [16] = '{8'h00, 8'h29, 8'h09, 8'h11,
      8'h49, 8'h69, 8'h51, 8'h12, 8'h0B, 8'h2B, 8'h1C, 8'h3C, 8'h1D, 8'h3D,
      8'h00, 8'h00};

   bectl_regs dut_u (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr),
      .bus_cs_n(bus_cs_n), .bus_write(bus_write), .bus_data_in(bus_data_in),
      .bus_data_out(bus_data_out), .bus_data_oe_n(oe_n),
      .eth_enable_bit(eth_en), .eth_dip_on_n(dip_n),
      .slave_type_high_bit(type_hi), .slave_type_low_bit(type_lo),
      .aux_addr_mode_low(aux_lo), .codec_fsync(fsync),
      .route_dest(route_dest), .route_iface(route_iface),
      .route_from_host_port(host_port), .mezz_loopback(loopback),
      .host_phy_enable(host_phy), .slave_phy_enable(slave_phy),
      .codec_wideband_enable(wide), .slave_type_code(type_code),
      .slave_port_addr_mode(addr_mode), .trace_buffer_enable(trace_en),
      .codec_path_select(codec_path), .tsi_frame_sync(tsi_fs));

   bectl_host_model host_u (.sys_clk(sys_clk), .bus_addr(bus_addr),
      .bus_cs_n(bus_cs_n), .bus_write(bus_write), .bus_data_in(bus_data_in),
      .bus_data_out(bus_data_out), .bus_data_oe_n(oe_n),
      .eth_enable_bit(eth_en), .eth_dip_on_n(dip_n));

   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      fs_prev <= tsi_fs;
      if (tsi_fs === 1'b1 && fs_prev === 1'b0) begin
         fs_count <= fs_count + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [0:7] d;
      logic       oe;
      check("dest", 8'(route_dest), 8'h00);
      check("phys", {5'h00, host_phy, slave_phy, wide}, 8'h00);
      check("addr_mode", {5'h00, addr_mode}, 8'h04);
      check("trace_path", {6'h00, trace_en, codec_path}, 8'h00);
      host_u.rd(BECTL_ADDR_ROUTE, d, oe);
      check("route_rd", d, 8'h00);
      check("route_oe_n", {7'h00, oe}, 8'h00);
      host_u.rd(BECTL_ADDR_MISC, d, oe);
      check("misc_rd", d, 8'h80);
   endtask

   task automatic t_rw();
      logic [0:7] d;
      logic       oe;
      host_u.wr(BECTL_ADDR_ROUTE, 8'hFF);
      host_u.rd(BECTL_ADDR_ROUTE, d, oe);
      check("route_ro_bit", d, 8'hFE);
      settle(2);
      check("phys", {5'h00, host_phy, slave_phy, wide}, 8'h07);
      aux_lo = 2'b11;
      host_u.wr(BECTL_ADDR_MISC, 8'h5A);
      host_u.rd(BECTL_ADDR_MISC, d, oe);
      check("misc_rw", d, 8'h5A);
      settle(2);
      check("addr_mode", {5'h00, addr_mode}, 8'h03);
      check("trace_path", {6'h00, trace_en, codec_path}, 8'h02);
      host_u.wr(BECTL_ADDR_MISC, 8'hA0);
      settle(3);
      check("addr_mode", {5'h00, addr_mode}, 8'h07);
      check("trace_path", {6'h00, trace_en, codec_path}, 8'h01);
   endtask

   task automatic t_unmapped();
      logic [0:7] d;
      logic       oe;
      host_u.wr(6'h25, 8'h55);
      host_u.wr(6'h2C, 8'h55);
      host_u.rd(BECTL_ADDR_ROUTE, d, oe);
      check("route_kept", d, 8'hFE);
      host_u.rd(6'h25, d, oe);
      check("unmapped_oe_n", {7'h00, oe}, 8'h01);
   endtask

   task automatic t_modes();
      logic [7:0] e;
      host_u.eth_on(1'b1, 1'b0);
      for (int m = 0; m < 16; m++) begin
         e = route_tab[m];
         host_u.wr(BECTL_ADDR_ROUTE, {m[3:0], 4'h0});
         settle(4);
         check("dest", 8'(route_dest), {5'h00, e[2:0]});
         check("iface", 8'(route_iface), {6'h00, e[4:3]});
         if (e[2:0] != 3'h0) begin
            check("port_lb", 8'({loopback, host_port}), 8'(e[6:5]));
         end
      end
      host_u.wr(BECTL_ADDR_ROUTE, 8'h20);
      host_u.eth_on(1'b0, 1'b0);
      settle(4);
      check("gated_bit", 8'(route_dest), 8'h00);
      host_u.eth_on(1'b1, 1'b1);
      settle(5);
      check("gated_dip", 8'(route_dest), 8'h00);
      host_u.eth_on(1'b1, 1'b0);
      settle(5);
      check("ungated", 8'(route_dest), 8'h01);
   endtask

   task automatic t_strap();
      logic [0:7] d;
      logic       oe;
      type_hi = 1'b1;
      type_lo = 1'b1;
      settle(5);
      check("type_code", {6'h00, type_code}, 8'h03);
      host_u.wr(BECTL_ADDR_ROUTE, 8'h08);
      host_u.rd(BECTL_ADDR_ROUTE, d, oe);
      check("type_bit", d, 8'h09);
      check("phys", {5'h00, host_phy, slave_phy, wide}, 8'h04);
      type_hi = 1'b0;
      settle(5);
      check("type_code", {6'h00, type_code}, 8'h01);
   endtask

   task automatic pulses();
      repeat (8) begin
         fsync = 1'b1;
         settle(2);
         fsync = 1'b0;
         settle(6);
      end
      settle(4);
   endtask

   task automatic t_fsync();
      fs_count = 0;
      pulses();
      check("sync_narrow", 8'(fs_count), 8'h08);
      host_u.wr(BECTL_ADDR_ROUTE, 8'h06);
      settle(2);
      check("phys", {5'h00, host_phy, slave_phy, wide}, 8'h03);
      fs_count = 0;
      pulses();
      // even pulse count, so the start phase does not matter
      check("sync_wide", 8'(fs_count), 8'h04);
   endtask

   task automatic t_rerun();
      logic [0:7] d;
      logic       oe;
      host_u.wr(BECTL_ADDR_ROUTE, 8'h2E);
      host_u.wr(BECTL_ADDR_MISC, 8'h7F);
      check("dest_pre", 8'(route_dest), 8'h01);
      // mid-run reset must clear written state
      srst = 1'b1;
      settle(2);
      srst = 1'b0;
      settle(3);
      check("dest", 8'(route_dest), 8'h00);
      check("phys", {5'h00, host_phy, slave_phy, wide}, 8'h00);
      check("addr_mode", {5'h00, addr_mode}, 8'h07);
      host_u.rd(BECTL_ADDR_ROUTE, d, oe);
      check("route_rd", d, 8'h01);
      host_u.rd(BECTL_ADDR_MISC, d, oe);
      check("misc_rd", d, 8'h80);
   endtask

   initial begin
      sys_clk = 1'b0;
      srst = 1'b1;
      type_hi = 1'b0;
      type_lo = 1'b0;
      aux_lo = 2'b00;
      fsync = 1'b0;
      fs_prev = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      cycles = 0;
      fs_count = 0;
      settle(4);
      srst = 1'b0;
      settle(3);
      t_reset();
      t_rw();
      t_unmapped();
      t_modes();
      t_strap();
      t_fsync();
      t_rerun();
      print_verdict();
   end
endmodule
